/* verilog/vip_pkg.sv */
package vip_pkg;

	// register byte addresses
	localparam logic [31:0] ADDR_BASE = 32'hFFFF0014;
	localparam logic [31:0] ADDR_VEC = 32'hFFFF001C;
	localparam logic [31:0] ADDR_PRIO0 = 32'hFFFF0020;
	localparam logic [31:0] ADDR_PRIO1 = 32'hFFFF0024;
	localparam logic [31:0] ADDR_PRIO2 = 32'hFFFF0028;
	localparam logic [31:0] ADDR_PRIO3 = 32'hFFFF002C;
	localparam logic [31:0] ADDR_NEST = 32'hFFFF0030;
	localparam logic [31:0] ADDR_INSERV = 32'hFFFF003C;

	// values after reset
	localparam logic [31:0] RST_REG = 32'h00000000;
	localparam logic [15:0] RST_BASE = 16'h0000;
	localparam logic [7:0] RST_INSERV = 8'h00;

	// writable bits of each register, reserved bits stay zero
	localparam logic [31:0] MASK_BASE = 32'h0000FFFF;
	localparam logic [31:0] MASK_PRIO0 = 32'h77777770;
	localparam logic [31:0] MASK_PRIO1 = 32'h77777707;
	localparam logic [31:0] MASK_PRIO2 = 32'h77777777;
	localparam logic [31:0] MASK_PRIO3 = 32'h00007777;
	localparam logic [31:0] MASK_NEST = 32'h00000001;
	localparam logic [31:0] MASK_INSERV = 32'h000000FF;

	// vector word field positions
	localparam int VEC_BASE_LSB = 7;
	localparam int VEC_BASE_MSB = 22;
	localparam int VEC_IDX_LSB = 2;
	localparam int VEC_IDX_MSB = 6;
	localparam int NEST_EN_BIT = 0;

	// sources and levels
	localparam int MAX_SRC = 28;
	localparam int NUM_LEVELS = 8;
	localparam logic [3:0] NO_BLOCK = 4'h8;
	localparam logic [2:0] LEVEL_FIXED = 3'h7;

	// bit position of each source's level in {prio3, prio2, prio1, prio0}
	localparam logic [6:0] POS_NONE = 7'h7F;
	localparam logic [6:0] PRIO_POS [MAX_SRC] = '{
		7'h7F, 7'h04, 7'h08, 7'h0C, 7'h10, 7'h14, 7'h18, 7'h1C,
		7'h28, 7'h2C, 7'h30, 7'h34, 7'h38, 7'h3C, 7'h20, 7'h40,
		7'h44, 7'h48, 7'h4C, 7'h50, 7'h54, 7'h58, 7'h5C, 7'h60,
		7'h64, 7'h68, 7'h6C, 7'h7F
	};

	// bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : vip_pkg

/* verilog/vip_res_if.sv */
`timescale 1ns/1ps
interface vip_res_if #(parameter int N_SRC = 28);
	logic [N_SRC-1:0] src_active;
	logic [127:0] levels_flat;
	logic nest_en;
	logic [7:0] in_service;
	logic win_valid;
	logic [4:0] win_idx;
	logic [2:0] win_level;

	modport ctrl (
		output src_active,
		output levels_flat,
		output nest_en,
		output in_service,
		input win_valid,
		input win_idx,
		input win_level
	);

	modport res (
		input src_active,
		input levels_flat,
		input nest_en,
		input in_service,
		output win_valid,
		output win_idx,
		output win_level
	);
endinterface : vip_res_if

/* verilog/vip_resolver.sv */
`timescale 1ns/1ps
module vip_resolver #(
	parameter int N_SRC = 28
) (
	input wire logic clk,
	input wire logic sys_rst,
	vip_res_if.res rif
);

	logic [2:0] src_level [N_SRC];
	logic [3:0] block_level;
	logic next_valid;
	logic [4:0] next_idx;
	logic [2:0] next_level;
	logic win_valid;
	logic [4:0] win_idx;
	logic [2:0] win_level;

	// level map only covers the documented sources
	if (N_SRC < 1 || N_SRC > vip_pkg::MAX_SRC)
	begin : g_check
		$error("vip_resolver: N_SRC must be 1 to 28");
	end

	// per-source level taken from its priority field; sources 0 and 27 have none and are fixed at level 7
	for (genvar g = 0; g < N_SRC; g++)
	begin : g_lvl
		if (vip_pkg::PRIO_POS[g] == vip_pkg::POS_NONE)
		begin : g_fix
			assign src_level[g] = vip_pkg::LEVEL_FIXED;
		end
		else
		begin : g_fld
			assign src_level[g] = rif.levels_flat[vip_pkg::PRIO_POS[g] +: 3];
		end
	end

	// blocking level and winner search
	always_comb
	begin
		block_level = vip_pkg::NO_BLOCK;
		for (int b = vip_pkg::NUM_LEVELS - 1; b >= 0; b--)
		begin
			if (rif.in_service[b])
				block_level = 4'(b);
		end
		next_valid = 1'b0;
		next_idx = 5'h00;
		next_level = 3'h0;
		for (int i = 0; i < N_SRC; i++)
		begin
			// without nesting, first active source wins and nothing blocks
			if (rif.src_active[i]
				&& (!rif.nest_en || {1'b0, src_level[i]} < block_level)
				&& (!next_valid || (rif.nest_en && src_level[i] < next_level)))
			begin
				next_valid = 1'b1;
				next_idx = 5'(i);
				next_level = src_level[i];
			end
		end
	end

	// registered winner
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			win_valid <= 1'b0;
			win_idx <= 5'h00;
			win_level <= 3'h0;
		end
		else
		begin
			win_valid <= next_valid;
			win_idx <= next_idx;
			win_level <= next_level;
		end
	end

	assign rif.win_valid = win_valid;
	assign rif.win_idx = win_idx;
	assign rif.win_level = win_level;

endmodule : vip_resolver

/* verilog/vip_top.sv */
// What this block does
// - vector word: zeros, base, winner index, zeros
// - winner index is five bits, 0 to 27
// - first priority register holds timer/soft/fault levels
// - second priority register holds serial/adc/flash/supply levels
// - third priority register holds pwm/external/i2c levels
// - fourth priority register holds logic-array/external levels
// - vector base bits writable, index read only, zero reset
// - nesting and priority only while enable bit set
// - base register keeps sixteen bits, upper read zero
// - vector read with nesting on sets in-service bit, blocks lower levels
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ps
module vip_top #(
	parameter int N_SRC = 28
) (
	input wire logic clk,
	input wire logic sys_rst,
	// enabled source status from the mask logic
	input wire logic [N_SRC-1:0] src_active,
	// request line to the core
	output logic irq_core,
	// state shown to the rest of the controller
	output logic normal_nesting_enable,
	output logic [7:0] in_service_priority,
	// axi4-lite write address
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	if (N_SRC < 1 || N_SRC > vip_pkg::MAX_SRC)
	begin : g_check
		$error("vip_top: N_SRC must be 1 to 28");
	end

	vip_res_if #(.N_SRC(N_SRC)) rif ();

	// software state
	logic [15:0] vector_table_base;
	logic [15:0] next_vector_table_base;
	logic [31:0] prio [4];
	logic [31:0] next_prio [4];
	logic nesting_control;
	logic next_nesting_control;
	logic [7:0] in_service;
	logic [7:0] next_in_service;

	// bus state
	logic aw_held;
	logic next_aw_held;
	logic [31:0] aw_addr;
	logic [31:0] next_aw_addr;
	logic w_held;
	logic next_w_held;
	logic [31:0] w_data;
	logic [31:0] next_w_data;
	logic [3:0] w_strb;
	logic [3:0] next_w_strb;
	logic bvalid;
	logic next_bvalid;
	logic [1:0] bresp;
	logic [1:0] next_bresp;
	logic rvalid;
	logic next_rvalid;
	logic [31:0] rdata;
	logic [31:0] next_rdata;
	logic [1:0] rresp;
	logic [1:0] next_rresp;

	logic do_write;
	logic rd_take;
	logic [31:0] vec_word;
	logic [31:0] wr_merged;
	logic [7:0] lowest_set;

	// byte-lane merge, then drop reserved bits
	function automatic logic [31:0] vip_merge(
		input logic [31:0] old,
		input logic [31:0] din,
		input logic [3:0] strb,
		input logic [31:0] mask
	);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++)
		begin
			if (strb[b])
				res[b*8 +: 8] = din[b*8 +: 8];
		end
		return res & mask;
	endfunction : vip_merge

	// resolver hookup
	assign rif.src_active = src_active;
	assign rif.levels_flat = {prio[3], prio[2], prio[1], prio[0]};
	assign rif.nest_en = nesting_control;
	assign rif.in_service = in_service;

	vip_resolver #(.N_SRC(N_SRC)) u_resolver (
		.clk(clk),
		.sys_rst(sys_rst),
		.rif(rif)
	);

	// vector word view
	always_comb
	begin
		vec_word = vip_pkg::RST_REG;
		vec_word[vip_pkg::VEC_BASE_MSB:vip_pkg::VEC_BASE_LSB] = vector_table_base;
		vec_word[vip_pkg::VEC_IDX_MSB:vip_pkg::VEC_IDX_LSB] = rif.win_idx;
	end

	// handshakes
	assign s_axi_awready = !aw_held && !bvalid;
	assign s_axi_wready = !w_held && !bvalid;
	assign s_axi_arready = !rvalid;
	assign do_write = aw_held && w_held && !bvalid;
	assign rd_take = s_axi_arvalid && !rvalid;
	// highest-priority in-service bit, only one cleared per write
	assign lowest_set = in_service & (~in_service + 8'h01);

	// register and bus next state
	always_comb
	begin
		next_vector_table_base = vector_table_base;
		next_prio = prio;
		next_nesting_control = nesting_control;
		next_in_service = in_service;
		next_aw_held = aw_held;
		next_aw_addr = aw_addr;
		next_w_held = w_held;
		next_w_data = w_data;
		next_w_strb = w_strb;
		next_bvalid = bvalid;
		next_bresp = bresp;
		next_rvalid = rvalid;
		next_rdata = rdata;
		next_rresp = rresp;
		wr_merged = vip_pkg::RST_REG;
		// capture address and data in either order
		if (s_axi_awvalid && s_axi_awready)
		begin
			next_aw_held = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			next_w_held = 1'b1;
			next_w_data = s_axi_wdata;
			next_w_strb = s_axi_wstrb;
		end
		if (bvalid && s_axi_bready)
			next_bvalid = 1'b0;
		// perform the write once both halves are in
		if (do_write)
		begin
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = vip_pkg::RESP_OKAY;
			unique case (aw_addr)
				vip_pkg::ADDR_BASE:
				begin
					wr_merged = vip_merge({16'h0000, vector_table_base}, w_data, w_strb,
						vip_pkg::MASK_BASE);
					next_vector_table_base = wr_merged[15:0];
				end
				vip_pkg::ADDR_VEC:
				begin
					wr_merged = vip_merge(vec_word, w_data, w_strb, 32'hFFFFFFFF);
					next_vector_table_base =
						wr_merged[vip_pkg::VEC_BASE_MSB:vip_pkg::VEC_BASE_LSB];
				end
				vip_pkg::ADDR_PRIO0:
					next_prio[0] = vip_merge(prio[0], w_data, w_strb, vip_pkg::MASK_PRIO0);
				vip_pkg::ADDR_PRIO1:
					next_prio[1] = vip_merge(prio[1], w_data, w_strb, vip_pkg::MASK_PRIO1);
				vip_pkg::ADDR_PRIO2:
					next_prio[2] = vip_merge(prio[2], w_data, w_strb, vip_pkg::MASK_PRIO2);
				vip_pkg::ADDR_PRIO3:
					next_prio[3] = vip_merge(prio[3], w_data, w_strb, vip_pkg::MASK_PRIO3);
				vip_pkg::ADDR_NEST:
				begin
					wr_merged = vip_merge({31'h0, nesting_control}, w_data, w_strb,
						vip_pkg::MASK_NEST);
					next_nesting_control = wr_merged[vip_pkg::NEST_EN_BIT];
				end
				vip_pkg::ADDR_INSERV:
				begin
					wr_merged = vip_merge(vip_pkg::RST_REG, w_data, w_strb, vip_pkg::MASK_INSERV);
					if ((wr_merged[7:0] & lowest_set) != 8'h00)
						next_in_service = in_service & ~lowest_set;
				end
				default:
					next_bresp = vip_pkg::RESP_SLVERR;
			endcase
		end
		// read side
		if (rvalid && s_axi_rready)
			next_rvalid = 1'b0;
		if (rd_take)
		begin
			next_rvalid = 1'b1;
			next_rresp = vip_pkg::RESP_OKAY;
			unique case (s_axi_araddr)
				vip_pkg::ADDR_BASE:
					next_rdata = {16'h0000, vector_table_base};
				vip_pkg::ADDR_VEC:
				begin
					next_rdata = vec_word;
					if (nesting_control && rif.win_valid)
						next_in_service[rif.win_level] = 1'b1;
				end
				vip_pkg::ADDR_PRIO0:
					next_rdata = prio[0];
				vip_pkg::ADDR_PRIO1:
					next_rdata = prio[1];
				vip_pkg::ADDR_PRIO2:
					next_rdata = prio[2];
				vip_pkg::ADDR_PRIO3:
					next_rdata = prio[3];
				vip_pkg::ADDR_NEST:
					next_rdata = {31'h0, nesting_control};
				vip_pkg::ADDR_INSERV:
					next_rdata = {24'h000000, in_service};
				default:
				begin
					next_rdata = vip_pkg::RST_REG;
					next_rresp = vip_pkg::RESP_SLVERR;
				end
			endcase
		end
	end

	// state registers, all clear on reset
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			vector_table_base <= vip_pkg::RST_BASE;
			for (int k = 0; k < 4; k++)
				prio[k] <= vip_pkg::RST_REG;
			nesting_control <= 1'b0;
			in_service <= vip_pkg::RST_INSERV;
			aw_held <= 1'b0;
			aw_addr <= vip_pkg::RST_REG;
			w_held <= 1'b0;
			w_data <= vip_pkg::RST_REG;
			w_strb <= 4'h0;
			bvalid <= 1'b0;
			bresp <= vip_pkg::RESP_OKAY;
			rvalid <= 1'b0;
			rdata <= vip_pkg::RST_REG;
			rresp <= vip_pkg::RESP_OKAY;
		end
		else
		begin
			vector_table_base <= next_vector_table_base;
			prio <= next_prio;
			nesting_control <= next_nesting_control;
			in_service <= next_in_service;
			aw_held <= next_aw_held;
			aw_addr <= next_aw_addr;
			w_held <= next_w_held;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			rvalid <= next_rvalid;
			rdata <= next_rdata;
			rresp <= next_rresp;
		end
	end

	// outputs
	assign irq_core = rif.win_valid;
	assign normal_nesting_enable = nesting_control;
	assign in_service_priority = in_service;
	assign s_axi_bvalid = bvalid;
	assign s_axi_bresp = bresp;
	assign s_axi_rvalid = rvalid;
	assign s_axi_rdata = rdata;
	assign s_axi_rresp = rresp;

endmodule : vip_top

/* bench/vip_monitor.sv */
`timescale 1ns/1ps
module vip_monitor #(
	parameter int N_SRC = 28
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [N_SRC-1:0] src_active,
	input wire logic irq_core,
	input wire logic normal_nesting_enable,
	input wire logic [7:0] in_service_priority,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	// read handshake steps
	sequence s_ar;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence s_r_wait;
		s_axi_rvalid && !s_axi_rready;
	endsequence

	// state after a reset edge
	property p_rst_zero;
		disable iff (1'b0) sys_rst |=> in_service_priority == 8'h00 && !normal_nesting_enable
			&& !irq_core;
	endproperty
	a_rst_zero: assert property (p_rst_zero) else $error("state not cleared by reset");
	property p_idle_quiet;
		(src_active == '0) [*3] |-> !irq_core;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("request with no source");
	property p_off_any;
		(!normal_nesting_enable && src_active != '0) [*3] |-> irq_core;
	endproperty
	a_off_any: assert property (p_off_any) else $error("active source not requested");
	property p_isr_set;
		(in_service_priority & ~$past(in_service_priority)) != 8'h00
			|-> $rose(s_axi_rvalid) && normal_nesting_enable;
	endproperty
	a_isr_set: assert property (p_isr_set) else $error("in-service set without read");
	property p_isr_one;
		$onehot0(in_service_priority & ~$past(in_service_priority));
	endproperty
	a_isr_one: assert property (p_isr_one) else $error("several in-service bits set");
	property p_err_zero;
		s_axi_rvalid && s_axi_rresp == vip_pkg::RESP_SLVERR |-> s_axi_rdata == 32'h00000000;
	endproperty
	a_err_zero: assert property (p_err_zero) else $error("error read not zero");
	property p_rd_lat;
		s_ar |=> s_axi_rvalid;
	endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
	property p_r_hold;
		s_r_wait |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data dropped");
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
endmodule : vip_monitor

/* bench/vip_core_model.sv */
`timescale 1ns/1ps
// core side: grants a vector read only on a request with nesting on
module vip_core_model (
	input wire logic clk,
	input wire logic irq_core,
	input wire logic nest_on,
	output logic read_ok
);
	// registered so the grant follows a settled request
	always_ff @(posedge clk)
	begin
		read_ok <= irq_core && nest_on;
	end
endmodule : vip_core_model

/* bench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	logic clk, irq_core, normal_nesting_enable, read_ok, s_axi_awready, s_axi_wready;
	logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp, brsp;
	logic [31:0] s_axi_rdata, got;
	logic [7:0] in_service_priority;
	logic sys_rst = 1'b1;
	logic [27:0] src_active = '0;
	logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0;
	int fail_count = 0;
	int total_checks = 0;
	logic [31:0] adr [8] = '{vip_pkg::ADDR_BASE, vip_pkg::ADDR_VEC, vip_pkg::ADDR_PRIO0,
		vip_pkg::ADDR_PRIO1, vip_pkg::ADDR_PRIO2, vip_pkg::ADDR_PRIO3, vip_pkg::ADDR_NEST,
		vip_pkg::ADDR_INSERV};
	logic [31:0] msk [4] = '{vip_pkg::MASK_PRIO0, vip_pkg::MASK_PRIO1, vip_pkg::MASK_PRIO2,
		vip_pkg::MASK_PRIO3};

	vip_top #(.N_SRC(28)) i_dut (.clk, .sys_rst, .src_active, .irq_core, .normal_nesting_enable,
		.in_service_priority, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready);
	vip_core_model i_core (.clk, .irq_core, .nest_on(normal_nesting_enable), .read_ok);

	// clock
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e)
		begin
			fail_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk

	// write: both halves offered together, each released once taken
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic ta, tw;
		ta = 0;
		tw = 0;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		while (!(ta && tw))
		begin
			@(negedge clk);
			ta = ta | s_axi_awready;
			tw = tw | s_axi_wready;
			@(posedge clk);
			if (ta) s_axi_awvalid <= 0;
			if (tw) s_axi_wvalid <= 0;
		end
		do @(negedge clk); while (s_axi_bvalid !== 1'b1);
		brsp = s_axi_bresp;
		@(posedge clk);
		s_axi_bready <= 0;
	endtask : wr

	task automatic rd(input logic [31:0] a);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do @(negedge clk); while (s_axi_arready !== 1'b1);
		@(posedge clk);
		s_axi_arvalid <= 0;
		do @(negedge clk); while (s_axi_rvalid !== 1'b1);
		got = s_axi_rdata;
		rsp = s_axi_rresp;
		@(posedge clk);
		s_axi_rready <= 0;
	endtask : rd

	task automatic rc(input logic [31:0] a, input logic [31:0] e);
		rd(a);
		chk(got, e);
		chk({30'h0, rsp}, {30'h0, vip_pkg::RESP_OKAY});
	endtask : rc

	// vector word with base all ones
	function automatic logic [31:0] vec(input logic [4:0] i);
		return {9'h000, 16'hFFFF, i, 2'h0};
	endfunction : vec

	task automatic t_regs();
		foreach (adr[i]) rc(adr[i], 32'h0);
		for (int i = 0; i < 4; i++)
		begin
			wr(adr[2 + i], 32'hFFFFFFFF);
			rc(adr[2 + i], msk[i]);
		end
		wr(vip_pkg::ADDR_BASE, 32'h5A5AA5C3);
		chk({30'h0, brsp}, {30'h0, vip_pkg::RESP_OKAY});
		rc(vip_pkg::ADDR_BASE, 32'h0000A5C3);
		wr(vip_pkg::ADDR_VEC, 32'hFFFFFFFF);
		rc(vip_pkg::ADDR_BASE, 32'h0000FFFF);
		rc(vip_pkg::ADDR_VEC, vec(5'h00));
		rd(32'hFFFF0040);
		chk(got, 32'h0);
		chk({30'h0, rsp}, {30'h0, vip_pkg::RESP_SLVERR});
		wr(32'hFFFF0040, 32'hFFFFFFFF);
		chk({30'h0, brsp}, {30'h0, vip_pkg::RESP_SLVERR});
		rc(vip_pkg::ADDR_BASE, 32'h0000FFFF);
	endtask : t_regs

	// slow master: write and read in flight, answers held before ready
	task automatic t_stall();
		@(posedge clk);
		s_axi_awaddr <= vip_pkg::ADDR_BASE;
		s_axi_wdata <= 32'h0000FFFF;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do @(negedge clk); while ((s_axi_awready & s_axi_wready) !== 1'b1);
		@(posedge clk);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		s_axi_araddr <= vip_pkg::ADDR_BASE;
		s_axi_arvalid <= 1'b1;
		do @(negedge clk); while (s_axi_arready !== 1'b1);
		@(posedge clk);
		s_axi_arvalid <= 1'b0;
		repeat (3) @(posedge clk);
		s_axi_bready <= 1'b1;
		s_axi_rready <= 1'b1;
		@(negedge clk);
		chk({28'h0, s_axi_bresp, s_axi_rvalid, s_axi_bvalid}, 32'h3);
		got = s_axi_rdata;
		@(posedge clk);
		s_axi_bready <= 1'b0;
		s_axi_rready <= 1'b0;
		chk(got, 32'h0000FFFF);
	endtask : t_stall

	// nesting on: priority, blocking, tie on level
	task automatic t_prio();
		wr(vip_pkg::ADDR_PRIO0, 32'h00027000);
		wr(vip_pkg::ADDR_NEST, 32'hFFFFFFFF);
		rc(vip_pkg::ADDR_NEST, 32'h1);
		chk({31'h0, normal_nesting_enable}, 32'h1);
		src_active <= 28'h0000310;
		do @(negedge clk); while (read_ok !== 1'b1);
		rc(vip_pkg::ADDR_VEC, vec(5'h04));
		rc(vip_pkg::ADDR_INSERV, 32'h04);
		repeat (3) @(negedge clk);
		chk({31'h0, irq_core}, 32'h0);
		// higher level still nests over the one in service
		@(posedge clk);
		src_active <= 28'h0000312;
		do @(negedge clk); while (read_ok !== 1'b1);
		rc(vip_pkg::ADDR_VEC, vec(5'h01));
		rc(vip_pkg::ADDR_INSERV, 32'h05);
		chk({24'h0, in_service_priority}, 32'h05);
		wr(vip_pkg::ADDR_INSERV, 32'hFF);
		rc(vip_pkg::ADDR_INSERV, 32'h04);
		@(posedge clk);
		src_active <= 28'h0000300;
		wr(vip_pkg::ADDR_INSERV, 32'hFF);
		do @(negedge clk); while (read_ok !== 1'b1);
		rc(vip_pkg::ADDR_VEC, vec(5'h08));
		rc(vip_pkg::ADDR_INSERV, 32'h80);
		wr(vip_pkg::ADDR_INSERV, 32'hFF);
	endtask : t_prio

	// nesting off: lowest active index, no in-service
	task automatic t_off();
		wr(vip_pkg::ADDR_NEST, 32'h0);
		src_active <= 28'h0000018;
		repeat (3) @(negedge clk);
		chk({31'h0, irq_core}, 32'h1);
		rc(vip_pkg::ADDR_VEC, vec(5'h03));
		rc(vip_pkg::ADDR_INSERV, 32'h0);
	endtask : t_off

	task automatic end_sim();
		$display("checks=%0d mismatches=%0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_sim

	// main sequence
	initial
	begin
		repeat (12) @(posedge clk);
		sys_rst <= 1'b0;
		t_regs();
		t_stall();
		t_prio();
		t_off();
		end_sim();
	end

	// watchdog
	initial
	begin
		repeat (5000) @(posedge clk);
		fail_count++;
		end_sim();
	end
endmodule : tb_top

bind vip_top vip_monitor #(.N_SRC(N_SRC)) i_mon (.clk(clk), .sys_rst(sys_rst),
	.src_active(src_active), .irq_core(irq_core), .normal_nesting_enable(normal_nesting_enable),
	.in_service_priority(in_service_priority), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready));
